// [design/gpr_edge_irq.sv]
/*
 Per-pin edge detector with sticky status and an enable-gated request.
 Assumes levels arrive already registered in the ref_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none

`include "gpr_params.svh"

module gpr_edge_irq
    import gpr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    gpr_irq_if.edge_unit port_if
);

    gpr_edge_t st_q;
    gpr_edge_t st_d;

    always_comb
    begin
        gpr_pins_t rise_ev;
        gpr_pins_t fall_ev;
        gpr_pins_t hit;
        rise_ev = '0;
        fall_ev = '0;
        hit = '0;
        st_d = st_q;
        st_d.prev = port_if.level;
        st_d.primed = {st_q.primed[0], 1'b1};
        // Level resets low but idle pins sit high; wait until prev holds a real pad level
        rise_ev = port_if.level & ~st_q.prev & {`GPR_NUM_PINS{st_q.primed[1]}};
        fall_ev = ~port_if.level & st_q.prev & {`GPR_NUM_PINS{st_q.primed[1]}};
        // Only pins in input mode raise events
        hit = port_if.input_mode & ((port_if.rising & rise_ev) | (~port_if.rising & fall_ev));
        // Set wins over a clear in the same cycle
        st_d.status = (st_q.status & ~port_if.clear) | hit;
        st_d.irq = |(st_d.status & port_if.enable);
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign port_if.status = st_q.status;
    assign port_if.irq = st_q.irq;

endmodule : gpr_edge_irq

`default_nettype wire

// [design/gpr_top.sv]
/*
 General pin bank: direction, output, pull-up, peripheral takeover on
 two selectable locations, sleep hold, edge interrupts and radio pins.
 Assumes all inputs synchronous to ref_clk; the pad resolves the wire
 from pin_oe, pin_out and pin_pullup.
*/
`timescale 1ns/1ps
`default_nettype none

`include "gpr_params.svh"

module gpr_top
    import gpr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire gpr_pins_t pin_in,
    output var gpr_pins_t pin_out,
    output var gpr_pins_t pin_oe,
    output var gpr_pins_t pin_pullup,
    input wire gpr_pins_t sw_dir,
    input wire gpr_pins_t sw_out,
    input wire gpr_pins_t sw_pullup,
    output var gpr_pins_t pin_level,
    input wire gpr_pins_t irq_enable,
    input wire gpr_pins_t irq_rising,
    input wire gpr_pins_t irq_clear,
    output var gpr_pins_t irq_status,
    output var logic irq_req,
    input wire logic sleep_req,
    output var logic asleep,
    output var logic wake_event,
    input wire gpr_funcs_t func_enable,
    input wire gpr_funcs_t func_alt_sel,
    input wire gpr_funcs_t func_oe,
    input wire gpr_funcs_t func_out,
    output var gpr_funcs_t func_in,
    output var gpr_funcs_t func_active,
    input wire logic [3:0] retry_count,
    input wire logic antenna_select_enable,
    input wire logic antenna_select_complement,
    input wire logic radio_indicator_enable,
    input wire logic radio_tx_state,
    input wire logic radio_rx_state
);

    gpr_core_t st_q;
    gpr_core_t st_d;

    gpr_irq_if #(.W(`GPR_NUM_PINS)) irq_if ();

    // Pin location of a peripheral function
    function automatic gpr_idx_t func_pin(input int unsigned f, input logic alt);
        gpr_idx_t p;
        p = '0;
        unique case (f)
            0: p = alt ? `GPR_FN0_ALT_PIN : `GPR_FN0_STD_PIN;
            1: p = alt ? `GPR_FN1_ALT_PIN : `GPR_FN1_STD_PIN;
            default: p = `GPR_FN0_STD_PIN;
        endcase
        return p;
    endfunction : func_pin

    always_comb
    begin
        gpr_pins_t eff_oe;
        gpr_pins_t eff_out;
        gpr_funcs_t live;
        gpr_pins_t sw_touch;
        gpr_idx_t p;
        logic ant;
        eff_oe = '0;
        eff_out = '0;
        live = '0;
        sw_touch = '0;
        p = '0;
        ant = 1'b0;
        st_d = st_q;

        // Software path for pins nobody else owns
        eff_oe = sw_dir;
        eff_out = sw_out;
        // Held values persist until software moves that pin after wake
        eff_oe = (eff_oe & ~st_q.hold_v) | (st_q.hold_oe & st_q.hold_v);
        eff_out = (eff_out & ~st_q.hold_v) | (st_q.hold_out & st_q.hold_v);

        // Blocked functions need a fresh enable after wake
        live = func_enable & ~st_q.blocked & {`GPR_NUM_FUNC{~st_q.asleep}};
        for (int unsigned f = 0; f < `GPR_NUM_FUNC; f++)
        begin
            p = func_pin(f, func_alt_sel[f]);
            if (live[f])
            begin
                eff_oe[p] = func_oe[f];
                eff_out[p] = func_out[f];
            end
            st_d.func_in[f] = st_q.level[p];
        end

        // Radio pins are peripheral functions too
        ant = retry_count[0];
        if (antenna_select_enable && !st_q.asleep)
        begin
            eff_oe[`GPR_ANT_PIN] = 1'b1;
            eff_out[`GPR_ANT_PIN] = ant;
            // Complement optional; otherwise pin 13 keeps its GPIO path
            if (antenna_select_complement)
            begin
                eff_oe[`GPR_ANT_COMP_PIN] = 1'b1;
                eff_out[`GPR_ANT_COMP_PIN] = ~ant;
            end
        end
        if (radio_indicator_enable && !st_q.asleep)
        begin
            eff_oe[`GPR_TX_PIN] = 1'b1;
            eff_out[`GPR_TX_PIN] = radio_tx_state;
            eff_oe[`GPR_RX_PIN] = 1'b1;
            eff_out[`GPR_RX_PIN] = radio_rx_state;
        end

        st_d.level = pin_in;
        sw_touch = (sw_dir ^ st_q.dir_prev) | (sw_out ^ st_q.out_prev);
        st_d.dir_prev = sw_dir;
        st_d.out_prev = sw_out;
        st_d.fen_prev = func_enable;

        if (!st_q.asleep)
        begin
            // Pins drive per-pin direction and pull-up
            st_d.pin_oe = eff_oe;
            st_d.pin_out = eff_out;
            st_d.pin_pu = sw_pullup;
            st_d.in_mode = ~eff_oe;
            st_d.hold_v = st_q.hold_v & ~sw_touch;
            st_d.blocked = st_q.blocked & ~(func_enable & ~st_q.fen_prev);
            st_d.wake = 1'b0;
            if (sleep_req)
            begin
                st_d.asleep = 1'b1;
                // Snapshot of what the pins do at this moment
                st_d.hold_oe = eff_oe;
                st_d.hold_out = eff_out;
                st_d.hold_pu = sw_pullup;
                st_d.hold_v = '1;
                st_d.blocked = st_q.blocked | live;
            end
        end
        else
        begin
            // Pads frozen to the snapshot for the whole sleep
            st_d.pin_oe = st_q.hold_oe;
            st_d.pin_out = st_q.hold_out;
            st_d.pin_pu = st_q.hold_pu;
            st_d.in_mode = ~st_q.hold_oe;
            // Sleep ends on an enabled pending edge (flagged as wake) or when sleep_req drops
            st_d.wake = irq_if.irq;
            if (!sleep_req || irq_if.irq)
            begin
                st_d.asleep = 1'b0;
            end
        end
        st_d.active = st_d.fen_prev & ~st_d.blocked;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // Inputs with pull-ups, all peripherals off
            st_q <= '0;
            st_q.pin_oe <= `GPR_RST_DIR;
            st_q.pin_out <= `GPR_RST_OUT;
            st_q.pin_pu <= `GPR_RST_PULLUP;
            st_q.hold_pu <= `GPR_RST_PULLUP;
            st_q.dir_prev <= `GPR_RST_DIR;
            st_q.out_prev <= `GPR_RST_OUT;
            st_q.in_mode <= '1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign irq_if.level = st_q.level;
    assign irq_if.input_mode = st_q.in_mode;
    assign irq_if.enable = irq_enable;
    assign irq_if.rising = irq_rising;
    assign irq_if.clear = irq_clear;

    gpr_edge_irq u_edge (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .port_if(irq_if.edge_unit)
    );

    // Outputs straight from flip-flops
    assign pin_out = st_q.pin_out;
    assign pin_oe = st_q.pin_oe;
    assign pin_pullup = st_q.pin_pu;
    assign pin_level = st_q.level;
    assign irq_status = irq_if.status;
    assign irq_req = irq_if.irq;
    assign asleep = st_q.asleep;
    assign wake_event = st_q.wake;
    assign func_in = st_q.func_in;
    // Blocked set stays internal; only the registered active view leaves
    assign func_active = st_q.active;

endmodule : gpr_top

`default_nettype wire

// [inc/gpr_irq_if.sv]
/*
 Carrier between the pin core and the edge interrupt unit.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface gpr_irq_if #(
    parameter int W = 18
);
    logic [W-1:0] level;
    logic [W-1:0] input_mode;
    logic [W-1:0] enable;
    logic [W-1:0] rising;
    logic [W-1:0] clear;
    logic [W-1:0] status;
    logic irq;

    modport core (
        output level,
        output input_mode,
        output enable,
        output rising,
        output clear,
        input status,
        input irq
    );

    modport edge_unit (
        input level,
        input input_mode,
        input enable,
        input rising,
        input clear,
        output status,
        output irq
    );
endinterface : gpr_irq_if

`default_nettype wire

// [inc/gpr_params.svh]
/*
 Constants for the general pin bank: pin count, fixed pin roles,
 peripheral pin locations and reset values.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef GPR_PARAMS_SVH
`define GPR_PARAMS_SVH

`define GPR_NUM_PINS 18
`define GPR_NUM_FUNC 2
`define GPR_PIN_IDX_W 5

`define GPR_ANT_PIN 5'h0_0c
`define GPR_ANT_COMP_PIN 5'h0_0d
`define GPR_TX_PIN 5'h0_03
`define GPR_RX_PIN 5'h0_02

`define GPR_FN0_STD_PIN 5'h0_00
`define GPR_FN0_ALT_PIN 5'h0_0e
`define GPR_FN1_STD_PIN 5'h0_01
`define GPR_FN1_ALT_PIN 5'h0_0f

`define GPR_RST_DIR 18'h0_0000
`define GPR_RST_OUT 18'h0_0000
`define GPR_RST_PULLUP 18'h3_ffff

`endif

// [inc/gpr_pkg.sv]
/*
 Types shared by the general pin bank modules.
 Assumes gpr_params.svh on the include path.
*/
`include "gpr_params.svh"

package gpr_pkg;

    typedef logic [`GPR_NUM_PINS-1:0] gpr_pins_t;
    typedef logic [`GPR_NUM_FUNC-1:0] gpr_funcs_t;
    typedef logic [`GPR_PIN_IDX_W-1:0] gpr_idx_t;

    typedef struct packed {
        gpr_pins_t pin_oe;
        gpr_pins_t pin_out;
        gpr_pins_t pin_pu;
        gpr_pins_t level;
        gpr_pins_t hold_oe;
        gpr_pins_t hold_out;
        gpr_pins_t hold_pu;
        gpr_pins_t hold_v;
        gpr_pins_t dir_prev;
        gpr_pins_t out_prev;
        gpr_pins_t in_mode;
        gpr_funcs_t blocked;
        gpr_funcs_t fen_prev;
        gpr_funcs_t func_in;
        gpr_funcs_t active;
        logic asleep;
        logic wake;
    } gpr_core_t;

    typedef struct packed {
        gpr_pins_t prev;
        gpr_pins_t status;
        logic irq;
        logic [1:0] primed;
    } gpr_edge_t;

endpackage : gpr_pkg

// [sim/gpr_pads.sv]
/* Board side of the pins: the pad wire seen by pin_in.
 Assumes the bench decides which pins outside circuitry drives. */
`timescale 1ns/1ps
`default_nettype none
module gpr_pads
    import gpr_pkg::*;
(
    input wire logic ref_clk,
    input wire gpr_pins_t pin_out,
    input wire gpr_pins_t pin_oe,
    input wire gpr_pins_t pin_pullup,
    input wire gpr_pins_t ext_en,
    input wire gpr_pins_t ext_val,
    output var gpr_pins_t pin_in
);
    gpr_pins_t churn_q = '0;
    // Undriven, unpulled pins churn so a stale level never passes
    always_ff @(posedge ref_clk)
        churn_q <= ~churn_q;
    always_comb
        pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & (pin_pullup | churn_q));
endmodule : gpr_pads
`default_nettype wire

// [sim/gpr_top_assertions.sv]
/* Port checker for the general pin bank, bound to gpr_top.
 Assumes every port is sampled on the rising edge of ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module gpr_top_chk
    import gpr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire gpr_pins_t pin_in,
    input wire gpr_pins_t pin_out,
    input wire gpr_pins_t pin_oe,
    input wire gpr_pins_t pin_pullup,
    input wire gpr_pins_t pin_level,
    input wire gpr_pins_t irq_enable,
    input wire gpr_pins_t irq_rising,
    input wire gpr_pins_t irq_clear,
    input wire gpr_pins_t irq_status,
    input wire logic irq_req,
    input wire logic sleep_req,
    input wire logic asleep,
    input wire logic wake_event,
    input wire logic [3:0] retry_count,
    input wire logic antenna_select_enable,
    input wire logic antenna_select_complement,
    input wire logic radio_indicator_enable,
    input wire logic radio_tx_state,
    input wire logic radio_rx_state
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    level_readback_a: assert property ($past(reset_n) |-> pin_level == $past(pin_in))
        else $error("pin level not one cycle behind pad");
    antenna_select_a: assert property (!asleep && antenna_select_enable
        |=> pin_oe[12] && pin_out[12] == $past(retry_count[0])) else $error("antenna select wrong");
    antenna_comp_a: assert property (!asleep && antenna_select_enable && antenna_select_complement
        |=> pin_oe[13] && pin_out[13] == !$past(retry_count[0])) else $error("antenna complement wrong");
    radio_marks_a: assert property (!asleep && radio_indicator_enable |=> pin_oe[3:2] == 2'b11
        && pin_out[3:2] == {$past(radio_tx_state), $past(radio_rx_state)}) else $error("radio pins wrong");
    status_sticky_a: assert property (($past(irq_status) & ~$past(irq_clear) & ~irq_status) == '0)
        else $error("status dropped without clear");
    baseline_quiet_a: assert property (!$past(reset_n, 3) |-> irq_status == '0)
        else $error("edge status right after reset");
    request_gate_a: assert property ($stable(irq_enable) |-> irq_req == |(irq_status & irq_enable))
        else $error("request not status and enable");
    rising_edge_a: assert property ($past(reset_n, 3) && $rose(pin_level[4]) && irq_rising[4] && !asleep
        && !pin_oe[4] && !$past(pin_oe[4]) && !$past(pin_oe[4], 2) |=> irq_status[4]) else $error("edge missed");
    output_quiet_a: assert property (((irq_status & ~$past(irq_status)) & $past(pin_oe)
        & $past(pin_oe, 2) & $past(pin_oe, 3)) == '0) else $error("output pin set status");
    sleep_entry_a: assert property (!asleep && sleep_req |=> asleep) else $error("sleep not entered");
    sleep_hold_a: assert property (asleep && $past(asleep) |-> $stable(pin_oe) && $stable(pin_out)
        && $stable(pin_pullup)) else $error("pads moved while asleep");
    wake_up_a: assert property (asleep && irq_req |=> !asleep && wake_event) else $error("no wake");
    cover property (wake_event);
    cover property (asleep && $past(asleep));
    cover property (irq_req && !asleep);
endmodule : gpr_top_chk
bind gpr_top gpr_top_chk u_chk (.*);
`default_nettype wire

// [sim/gpr_top_bench.sv]
/* Self-checking bench for the general pin bank.
 Assumes gpr_pads models the board; inputs change on falling edges. */
`timescale 1ns/1ps
`default_nettype none
module gpr_top_bench
    import gpr_pkg::*;
;
    logic ref_clk = 0, reset_n = 0, irq_req, sleep_req, asleep, wake_event;
    gpr_pins_t pin_in, pin_out, pin_oe, pin_pullup, sw_dir, sw_out, sw_pullup, pin_level;
    gpr_pins_t irq_enable, irq_rising, irq_clear, irq_status, ext_en, ext_val;
    gpr_funcs_t func_enable, func_alt_sel, func_oe, func_out, func_in, func_active;
    logic [3:0] retry_count;
    logic antenna_select_enable, antenna_select_complement, radio_indicator_enable, radio_tx_state, radio_rx_state;
    int fail_count = 0, checked = 0;
    gpr_top dut (.*);
    gpr_pads pads (.*);
    always #25 ref_clk = ~ref_clk;
    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : step
    task automatic chk(input gpr_pins_t got, input gpr_pins_t exp, input string what);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task automatic t_sw;
        sw_dir = 18'h0_00f0; sw_out = 18'h0_0050; sw_pullup = 18'h3_0f0f;
        ext_en = 18'h3_ff0f; ext_val = 18'h2_a50a;
        step(2);
        chk(pin_oe, 18'h0_00f0, "direction");
        chk(pin_out & pin_oe, 18'h0_0050, "output value");
        chk(pin_pullup, 18'h3_0f0f, "pull-ups");
        chk(pin_level, 18'h2_a55a, "level readback");
    endtask : t_sw
    task automatic t_func;
        ext_en = 18'h3_bf0e; func_enable = 2'b01; func_oe = 2'b01; func_out = 2'b01;
        step(2);
        chk(pin_oe & pin_out & 18'h0_4001, 18'h0_0001, "peripheral on standard pin");
        chk(func_active, 2'b01, "peripheral active");
        func_alt_sel = 2'b01;
        step(2);
        chk(pin_oe & pin_out & 18'h0_4001, 18'h0_4000, "peripheral on alternate pin");
        step(1);
        chk(func_in, 2'b11, "function input follows its pin");
        func_enable = 2'b00;
    endtask : t_func
    task automatic t_irq;
        sw_dir = 18'h0_0020; sw_out = 0; ext_en = 18'h3_ffdf; ext_val = 18'h0_0040;
        irq_rising = 18'h3_ffbf; irq_clear = '1;
        step(4);
        irq_clear = 0; ext_val = 18'h0_0010; sw_out = 18'h0_0020;
        step(3);
        chk(irq_status, 18'h0_0050, "edge status");
        chk(irq_req, 0, "request while disabled");
        irq_enable = 18'h0_0010;
        step(1);
        chk(irq_req, 1, "request when enabled");
        irq_clear = 18'h0_0050;
        step(1);
        irq_clear = 0;
        step(1);
        chk(irq_status, 0, "status cleared");
        chk(irq_req, 0, "request cleared");
    endtask : t_irq
    task automatic t_sleep;
        sw_dir = 0; sw_pullup = 18'h0_0f0f; ext_en = 18'h3_fffe; ext_val = 0;
        func_alt_sel = 0; func_out = 2'b01; func_enable = 2'b01;
        step(3);
        sleep_req = 1;
        step(2);
        chk(asleep, 1, "asleep");
        sw_pullup = '1; sw_dir = 18'h0_0f00; func_out = 0;
        step(2);
        chk(pin_oe & pin_out, 18'h0_0001, "held output");
        chk(pin_pullup, 18'h0_0f0f, "held pull-ups");
        ext_val = 18'h0_0010;
        for (int i = 0; i < 10 && wake_event !== 1'b1; i++)
            step(1);
        chk(wake_event, 1, "wake event");
        sleep_req = 0; irq_clear = 18'h0_0010;
        step(1);
        irq_clear = 0;
        chk(asleep, 0, "awake");
        step(1);
        chk(pin_oe & pin_out & 18'h0_0001, 18'h0_0001, "held value after wake");
        chk(func_active, 0, "peripheral stays off");
        sw_dir = 18'h0_0f01;
        step(2);
        chk(pin_out & 18'h0_0001, 0, "software owns pin");
        func_enable = 0;
        step(1);
        func_enable = 2'b01; func_out = 2'b01;
        step(2);
        chk(func_active, 2'b01, "peripheral re-enabled");
        chk(pin_out & 18'h0_0001, 18'h0_0001, "peripheral drives again");
    endtask : t_sleep
    task automatic t_radio;
        ext_en = 18'h0_cff3; func_enable = 0; sw_dir = 0;
        antenna_select_enable = 1; antenna_select_complement = 1; radio_indicator_enable = 1;
        for (int r = 0; r < 4; r++)
        begin
            retry_count = 4'(r); radio_tx_state = r[0]; radio_rx_state = !r[0];
            step(2);
            chk(pin_oe & pin_out & 18'h0_300c, r[0] ? 18'h0_1008 : 18'h0_2004, "radio pins");
        end
        antenna_select_complement = 0; sw_dir = 18'h0_2000; sw_out = 18'h0_2000;
        step(2);
        chk(pin_oe & pin_out & 18'h0_3000, 18'h0_3000, "pin 13 ordinary");
    endtask : t_radio
    initial
    begin
        // Unused pins parked as pulled inputs
        sw_dir = 0; sw_out = 0; sw_pullup = '1; irq_enable = 0; irq_rising = '1; irq_clear = 0;
        ext_en = 0; ext_val = 0; sleep_req = 0; func_enable = 0; func_alt_sel = 0; func_oe = 0; func_out = 0;
        retry_count = 0; antenna_select_enable = 0; antenna_select_complement = 0;
        radio_indicator_enable = 0; radio_tx_state = 0; radio_rx_state = 0;
        step(10);
        chk(pin_oe, 0, "reset direction");
        chk(pin_pullup, '1, "reset pull-ups");
        reset_n = 1;
        step(2);
        chk(func_active, 0, "reset peripherals");
        chk(irq_status, 0, "no edge from reset");
        t_sw;
        t_func;
        t_irq;
        t_sleep;
        t_radio;
        stop_test;
    end
    initial
    begin
        // Scenarios need about 60 cycles; allow far more
        #100000;
        fail_count++;
        stop_test;
    end
endmodule : gpr_top_bench
`default_nettype wire
